/* hdl/mcuid_pkg.sv */
// Constants and types shared by the instruction decoder
package mcuid_pkg;

  // ---------------------------------------------------------------
  // Word layout and instruction classes
  // ---------------------------------------------------------------
  localparam int          WORD_W      = 14;
  localparam logic [1:0]  CLS_BYTE    = 2'h0;
  localparam logic [1:0]  CLS_BIT     = 2'h1;
  localparam logic [1:0]  CLS_BRANCH  = 2'h2;
  localparam logic [1:0]  CLS_LIT     = 2'h3;

  // ---------------------------------------------------------------
  // Byte-oriented operation codes, bits 11:8
  // ---------------------------------------------------------------
  localparam logic [3:0]  OP_MISC     = 4'h0;
  localparam logic [3:0]  OP_CLEAR    = 4'h1;
  localparam logic [3:0]  OP_SUB      = 4'h2;
  localparam logic [3:0]  OP_DEC      = 4'h3;
  localparam logic [3:0]  OP_OR       = 4'h4;
  localparam logic [3:0]  OP_AND      = 4'h5;
  localparam logic [3:0]  OP_XOR      = 4'h6;
  localparam logic [3:0]  OP_ADD      = 4'h7;
  localparam logic [3:0]  OP_MOVE     = 4'h8;
  localparam logic [3:0]  OP_COM      = 4'h9;
  localparam logic [3:0]  OP_INC      = 4'hA;
  localparam logic [3:0]  OP_DECSZ    = 4'hB;
  localparam logic [3:0]  OP_RRC      = 4'hC;
  localparam logic [3:0]  OP_RLC      = 4'hD;
  localparam logic [3:0]  OP_SWAP     = 4'hE;
  localparam logic [3:0]  OP_INCSZ    = 4'hF;

  // ---------------------------------------------------------------
  // Fixed control words, low byte under 00 0000
  // ---------------------------------------------------------------
  localparam logic [7:0]  CW_RETURN   = 8'h08;
  localparam logic [7:0]  CW_INT_RET  = 8'h09;
  localparam logic [7:0]  CW_WDT      = 8'h64;
  localparam logic [7:0]  CW_SLEEP    = 8'h63;

  // ---------------------------------------------------------------
  // Timing, addresses and reset values
  // ---------------------------------------------------------------
  localparam int          OSC_PER_CYC = 4;
  localparam logic [1:0]  PH_TEST     = 2'(OSC_PER_CYC - 2);
  localparam logic [1:0]  PH_FETCH    = 2'(OSC_PER_CYC - 1);
  localparam logic [1:0]  PH_RST      = 2'h0;
  localparam logic [6:0]  TIMER0_ADDR = 7'h01;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  DEC_HIT     = 8'h01;
  localparam logic [7:0]  INC_HIT     = 8'hFF;

  typedef enum logic [4:0] {
    ALU_NONE  = 5'h00, ALU_ADD  = 5'h01, ALU_SUB  = 5'h02,
    ALU_AND   = 5'h03, ALU_OR   = 5'h04, ALU_XOR  = 5'h05,
    ALU_COM   = 5'h06, ALU_DEC  = 5'h07, ALU_INC  = 5'h08,
    ALU_MOVE  = 5'h09, ALU_RLC  = 5'h0A, ALU_RRC  = 5'h0B,
    ALU_SWAP  = 5'h0C, ALU_CLR  = 5'h0D, ALU_STORE = 5'h0E,
    ALU_BCLR  = 5'h0F, ALU_BSET = 5'h10, ALU_TEST = 5'h11,
    ALU_LOAD  = 5'h12, ALU_LSUB = 5'h13
  } mcuid_alu_t;

endpackage

/* hdl/mcuid_decoder.sv */
// Instruction decoder with cycle sequencing, skip and port read-back
`timescale 1ns/1ps

// Summary of operation
// - Accumulator-file arithmetic and logic opcodes, flag sets
// - Single-operand ops, rotates update carry, swap none
// - Clear, store, clear accumulator and no-operation codes
// - Decrement/increment skip when result is zero
// - Bit clear and set, bit index, file address
// - Bit test skips on clear or set
// - Literal add and subtract update three flags
// - Literal AND, OR, XOR update zero only
// - Load literal; return with literal two cycles
// - Call and jump carry eleven-bit target
// - Return, interrupt return, watchdog, standby words
// - Branch or passed test adds no-operation cycle
// - Port self-modify reads pin levels
// - Timer-zero write clears assigned prescaler
// - Destination bit picks accumulator or file
// - Instruction cycle is four oscillator periods
module mcuid_decoder
  import mcuid_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic [WORD_W-1:0] instr_word,
  input  wire logic [7:0]        file_data,
  input  wire logic              file_is_port,
  input  wire logic [7:0]        port_pins,
  input  wire logic              prescaler_to_timer,
  output logic                   fetch_req,
  output logic                   exec_nop,
  output logic                   nop_next,
  output mcuid_alu_t             alu_op,
  output logic                   src_literal,
  output logic                   dst_file,
  output logic                   dst_acc,
  output logic                   upd_carry,
  output logic                   upd_digit_carry,
  output logic                   upd_zero,
  output logic                   upd_to_pd,
  output logic                   watchdog_clear,
  output logic                   standby_enter,
  output logic                   pc_jump,
  output logic                   pc_call,
  output logic                   pc_return,
  output logic                   interrupt_return,
  output logic [6:0]             file_addr,
  output logic [2:0]             bit_idx,
  output logic [7:0]             literal,
  output logic [10:0]            target_addr,
  output logic                   prescaler_clear,
  output logic [7:0]             operand
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  phase;
    logic        pending;
    logic        exec_nop;
    mcuid_alu_t  alu;
    logic        src_lit;
    logic        dst_file;
    logic        dst_acc;
    logic        upd_c;
    logic        upd_dc;
    logic        upd_z;
    logic        upd_tp;
    logic        wdt;
    logic        sleep;
    logic        jump;
    logic        call;
    logic        ret;
    logic        iret;
    logic        skip_dec;
    logic        skip_inc;
    logic        skip_clr;
    logic        skip_set;
    logic [6:0]  addr;
    logic [2:0]  bidx;
    logic [7:0]  lit;
    logic [10:0] target;
    logic        presc;
    logic [7:0]  operand;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  sync3;
    logic [7:0]  pins;
  } mcuid_state_t;

  mcuid_state_t st_q;
  mcuid_state_t st_d;
  logic [1:0]   cls;
  logic [3:0]   op;
  logic         dbit;
  logic         two_cyc;
  logic         skip_hit;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    if (st_q.phase == PH_FETCH) begin
      st_d      = '0;
      st_d.pins = st_q.pins;
    end
    cls      = instr_word[13:12];
    op       = instr_word[11:8];
    dbit     = instr_word[7];
    two_cyc  = 1'b0;
    skip_hit = (st_q.skip_dec && st_q.operand == DEC_HIT) ||
               (st_q.skip_inc && st_q.operand == INC_HIT) ||
               (st_q.skip_clr && !st_q.operand[st_q.bidx]) ||
               (st_q.skip_set && st_q.operand[st_q.bidx]);
    st_d.phase = 2'(st_q.phase + 2'h1);
    // Pin levels through three stages; accepted once stages 2 and 3 agree
    st_d.sync1 = port_pins;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    if (st_q.sync2 == st_q.sync3) begin
      st_d.pins = st_q.sync3;
    end
    st_d.operand = file_is_port ? st_q.pins : file_data;
    if (st_q.phase == PH_TEST && skip_hit) begin
      st_d.pending = 1'b1;
    end
    if (st_q.phase == PH_FETCH) begin
      st_d.exec_nop = st_q.pending;
      st_d.addr     = instr_word[6:0];
      st_d.bidx     = instr_word[9:7];
      st_d.lit      = instr_word[7:0];
      st_d.target   = instr_word[10:0];
      if (!st_q.pending) begin
        case (cls)
          CLS_BYTE: begin
            st_d.dst_file = dbit;
            st_d.dst_acc  = !dbit;
            case (op)
              OP_ADD: {st_d.alu, st_d.upd_c, st_d.upd_dc, st_d.upd_z} =
                        {ALU_ADD, 3'h7};
              OP_SUB: {st_d.alu, st_d.upd_c, st_d.upd_dc, st_d.upd_z} =
                        {ALU_SUB, 3'h7};
              OP_AND:   {st_d.alu, st_d.upd_z} = {ALU_AND, 1'b1};
              OP_OR:    {st_d.alu, st_d.upd_z} = {ALU_OR, 1'b1};
              OP_XOR:   {st_d.alu, st_d.upd_z} = {ALU_XOR, 1'b1};
              OP_COM:   {st_d.alu, st_d.upd_z} = {ALU_COM, 1'b1};
              OP_DEC:   {st_d.alu, st_d.upd_z} = {ALU_DEC, 1'b1};
              OP_INC:   {st_d.alu, st_d.upd_z} = {ALU_INC, 1'b1};
              OP_MOVE:  {st_d.alu, st_d.upd_z} = {ALU_MOVE, 1'b1};
              OP_RLC:   {st_d.alu, st_d.upd_c} = {ALU_RLC, 1'b1};
              OP_RRC:   {st_d.alu, st_d.upd_c} = {ALU_RRC, 1'b1};
              OP_SWAP:  st_d.alu = ALU_SWAP;
              OP_DECSZ: {st_d.alu, st_d.skip_dec} = {ALU_DEC, 1'b1};
              OP_INCSZ: {st_d.alu, st_d.skip_inc} = {ALU_INC, 1'b1};
              OP_CLEAR: {st_d.alu, st_d.upd_z} = {ALU_CLR, 1'b1};
              OP_MISC: begin
                st_d.dst_acc = 1'b0;
                if (dbit) begin
                  st_d.alu = ALU_STORE;
                end else begin
                  st_d.dst_file = 1'b0;
                  case (instr_word[7:0])
                    CW_RETURN:  {st_d.ret, two_cyc} = 2'h3;
                    CW_INT_RET:
                      {st_d.ret, st_d.iret, two_cyc} = 3'h7;
                    CW_WDT:   {st_d.wdt, st_d.upd_tp} = 2'h3;
                    CW_SLEEP: {st_d.sleep, st_d.upd_tp} = 2'h3;
                    default:  st_d.alu = ALU_NONE;
                  endcase
                end
              end
              default: st_d.alu = ALU_NONE;
            endcase
          end
          CLS_BIT: begin
            case (op[3:2])
              2'h0: {st_d.alu, st_d.dst_file} = {ALU_BCLR, 1'b1};
              2'h1: {st_d.alu, st_d.dst_file} = {ALU_BSET, 1'b1};
              2'h2: {st_d.alu, st_d.skip_clr} = {ALU_TEST, 1'b1};
              default: {st_d.alu, st_d.skip_set} = {ALU_TEST, 1'b1};
            endcase
          end
          CLS_BRANCH: begin
            st_d.jump = op[3];
            st_d.call = !op[3];
            two_cyc   = 1'b1;
          end
          default: begin
            st_d.src_lit = 1'b1;
            st_d.dst_acc = 1'b1;
            casez (op)
              4'b00??: st_d.alu = ALU_LOAD;
              4'b01??: {st_d.alu, st_d.ret, two_cyc} =
                         {ALU_LOAD, 2'h3};
              4'b111?: {st_d.alu, st_d.upd_c, st_d.upd_dc, st_d.upd_z} =
                         {ALU_ADD, 3'h7};
              4'b110?: {st_d.alu, st_d.upd_c, st_d.upd_dc, st_d.upd_z} =
                         {ALU_LSUB, 3'h7};
              4'b1001: {st_d.alu, st_d.upd_z} = {ALU_AND, 1'b1};
              4'b1000: {st_d.alu, st_d.upd_z} = {ALU_OR, 1'b1};
              4'b1010: {st_d.alu, st_d.upd_z} = {ALU_XOR, 1'b1};
              default: {st_d.alu, st_d.dst_acc} = {ALU_NONE, 1'b0};
            endcase
          end
        endcase
      end
      st_d.presc   = st_d.dst_file && st_d.addr == TIMER0_ADDR &&
                     prescaler_to_timer;
      st_d.pending = two_cyc;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q          <= '0;
      st_q.phase    <= PH_RST;
      st_q.exec_nop <= 1'b1;
      st_q.alu      <= ALU_NONE;
      st_q.pins     <= BYTE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign fetch_req        = st_q.phase == PH_FETCH;
  assign alu_op           = st_q.alu;
  assign operand          = st_q.operand;
  assign {exec_nop, nop_next}           = {st_q.exec_nop, st_q.pending};
  assign {src_literal, dst_file}        = {st_q.src_lit, st_q.dst_file};
  assign {dst_acc, upd_carry}           = {st_q.dst_acc, st_q.upd_c};
  assign {upd_digit_carry, upd_zero}    = {st_q.upd_dc, st_q.upd_z};
  assign {upd_to_pd, watchdog_clear}    = {st_q.upd_tp, st_q.wdt};
  assign {standby_enter, pc_jump}       = {st_q.sleep, st_q.jump};
  assign {pc_call, pc_return}           = {st_q.call, st_q.ret};
  assign {interrupt_return, prescaler_clear} = {st_q.iret, st_q.presc};
  assign {file_addr, bit_idx}           = {st_q.addr, st_q.bidx};
  assign {literal, target_addr}         = {st_q.lit, st_q.target};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  fetch_period_a: assert property (
    fetch_req |=> !fetch_req [*3] ##1 fetch_req)
    else $error("fetch spacing not four clocks");
  add_flags_a: assert property (
    fetch_req && !nop_next && instr_word[13:8] == 6'h07 |=>
      alu_op == ALU_ADD && upd_carry && upd_digit_carry && upd_zero)
    else $error("add decode or flags wrong");
  logic_flags_a: assert property (
    fetch_req && !nop_next && instr_word[13:8] == 6'h3A |=>
      alu_op == ALU_XOR && upd_zero && !upd_carry && src_literal)
    else $error("literal xor decode wrong");
  rotate_flags_a: assert property (
    fetch_req && !nop_next && instr_word[13:8] == 6'h0D |=>
      alu_op == ALU_RLC && upd_carry && !upd_zero)
    else $error("rotate decode wrong");
  dest_bit_a: assert property (
    fetch_req && !nop_next && instr_word[13:8] == 6'h05 |=>
      dst_file == $past(instr_word[7]) && dst_acc != dst_file)
    else $error("destination select wrong");
  bit_field_a: assert property (
    fetch_req && !nop_next && instr_word[13:10] == 4'h5 |=>
      alu_op == ALU_BSET && bit_idx == $past(instr_word[9:7]) &&
      file_addr == $past(instr_word[6:0]) && !upd_zero)
    else $error("bit set fields wrong");
  skip_nop_a: assert property (
    fetch_req ##3 (skip_hit && !exec_nop) |-> ##2 exec_nop)
    else $error("passed test not followed by nop");
  branch_nop_a: assert property (
    fetch_req && !nop_next && instr_word[13:12] == CLS_BRANCH |=>
      (pc_jump || pc_call) ##4 exec_nop)
    else $error("branch second cycle not nop");
  wdt_word_a: assert property (
    fetch_req && !nop_next && instr_word == 14'h0064 |=>
      watchdog_clear && upd_to_pd && !standby_enter)
    else $error("watchdog word decode wrong");
  presc_clr_a: assert property (
    fetch_req && !nop_next && instr_word[13:7] == 7'h01 &&
      instr_word[6:0] == TIMER0_ADDR && prescaler_to_timer |=>
      prescaler_clear)
    else $error("prescaler not cleared");
  pin_read_a: assert property (
    file_is_port |=> operand == $past(st_q.pins))
    else $error("port read not from pins");

endmodule

/* sim/mcuid_mem_model.sv */
// Behavioural program memory and file register space
`timescale 1ns/1ps
module mcuid_mem_model
  import mcuid_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              fetch_req,
  input  wire logic [WORD_W-1:0] word_next,
  input  wire logic [6:0]        file_addr,
  output logic [WORD_W-1:0]      instr_word,
  output logic [7:0]             file_data
);
  logic [7:0]        regs [128];
  logic [WORD_W-1:0] last_q;

  // Word valid only in the fetch cycle, inverted otherwise
  assign instr_word = fetch_req ? word_next : ~last_q;
  assign file_data  = regs[file_addr];

  always @(posedge mclk) begin
    if (fetch_req) begin
      last_q <= word_next;
    end
  end

  initial begin
    foreach (regs[i]) regs[i] = 8'h00;
  end
endmodule

/* sim/mcuid_decoder_tb.sv */
// Self-checking testbench of the instruction decoder
`timescale 1ns/1ps
module mcuid_decoder_tb;
  import mcuid_pkg::*;
  logic              mclk, sys_rst, file_is_port, prescaler_to_timer;
  logic [WORD_W-1:0] word_next, instr_word;
  logic [7:0]        file_data, port_pins, literal, operand;
  logic              fetch_req, exec_nop, nop_next, src_literal;
  logic              dst_file, dst_acc, upd_carry, upd_digit_carry;
  logic              upd_zero, upd_to_pd, watchdog_clear, standby_enter;
  logic              pc_jump, pc_call, pc_return, interrupt_return;
  logic              prescaler_clear;
  mcuid_alu_t        alu_op;
  logic [6:0]        file_addr;
  logic [2:0]        bit_idx;
  logic [10:0]       target_addr;
  int                fail_count, samples_checked, gap;

  mcuid_decoder dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .instr_word(instr_word), .file_data(file_data),
    .file_is_port(file_is_port), .port_pins(port_pins),
    .prescaler_to_timer(prescaler_to_timer), .fetch_req(fetch_req),
    .exec_nop(exec_nop), .nop_next(nop_next), .alu_op(alu_op),
    .src_literal(src_literal), .dst_file(dst_file), .dst_acc(dst_acc),
    .upd_carry(upd_carry), .upd_digit_carry(upd_digit_carry),
    .upd_zero(upd_zero), .upd_to_pd(upd_to_pd),
    .watchdog_clear(watchdog_clear), .standby_enter(standby_enter),
    .pc_jump(pc_jump), .pc_call(pc_call), .pc_return(pc_return),
    .interrupt_return(interrupt_return), .file_addr(file_addr),
    .bit_idx(bit_idx), .literal(literal), .target_addr(target_addr),
    .prescaler_clear(prescaler_clear), .operand(operand));

  mcuid_mem_model mem_u (.mclk(mclk), .fetch_req(fetch_req),
    .word_next(word_next), .file_addr(file_addr),
    .instr_word(instr_word), .file_data(file_data));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", fail_count,
             samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask

  function automatic logic [9:0] got();
    return {alu_op, dst_file, dst_acc, upd_carry, upd_digit_carry,
            upd_zero};
  endfunction

  // Present a word, wait for its fetch, return in its decode cycle
  task automatic issue(input logic [WORD_W-1:0] w);
    int n;
    @(posedge mclk) word_next <= w;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > 10) begin
        fail_count++;
        end_of_test();
      end
    end while (fetch_req !== 1'b1);
    gap = n;
    @(negedge mclk);
  endtask

  // Filler after a word; checks whether it was discarded
  task automatic follow(input logic skipped);
    issue(14'h3E01);
    check({exec_nop, nop_next, alu_op},
          skipped ? {2'b10, ALU_NONE} : {2'b00, ALU_ADD});
  endtask

  function automatic logic [7:0] byte_exp(input logic [3:0] op);
    case (op)
      4'h7: return {ALU_ADD, 3'b111};
      4'h2: return {ALU_SUB, 3'b111};
      4'h5: return {ALU_AND, 3'b001};
      4'h4: return {ALU_OR, 3'b001};
      4'h6: return {ALU_XOR, 3'b001};
      4'h9: return {ALU_COM, 3'b001};
      4'h3: return {ALU_DEC, 3'b001};
      4'hA: return {ALU_INC, 3'b001};
      4'h8: return {ALU_MOVE, 3'b001};
      4'hD: return {ALU_RLC, 3'b100};
      4'hC: return {ALU_RRC, 3'b100};
      4'hE: return {ALU_SWAP, 3'b000};
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] lit_exp(input logic [3:0] n);
    case (n)
      4'h8: return {ALU_OR, 3'b001};
      4'h9: return {ALU_AND, 3'b001};
      4'hA: return {ALU_XOR, 3'b001};
      4'hC, 4'hD: return {ALU_LSUB, 3'b111};
      4'hE, 4'hF: return {ALU_ADD, 3'b111};
      default: return {ALU_LOAD, 3'b000};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic byte_ops();
    logic [7:0] e;
    logic       d;
    for (int i = 2; i < 15; i++) begin
      if (i == 11) continue;
      e = byte_exp(4'(i));
      d = i[0];
      issue({2'b00, 4'(i), d, 7'h05});
      check(got(), {e[7:3], d, ~d, e[2:0]});
      check({exec_nop, file_addr}, {1'b0, 7'h05});
    end
  endtask

  task automatic lit_ops();
    logic [7:0] e;
    for (int i = 0; i < 16; i++) begin
      if ((i >= 4 && i <= 7) || i == 11) continue;
      e = lit_exp(4'(i));
      issue({2'b11, 4'(i), 8'hA5});
      check(got(), {e[7:3], 2'b01, e[2:0]});
      check({src_literal, literal}, {1'b1, 8'hA5});
    end
  endtask

  task automatic fixed_ops();
    issue(14'h0185);
    check(got(), {ALU_CLR, 2'b10, 3'b001});
    issue(14'h0100);
    check(got(), {ALU_CLR, 2'b01, 3'b001});
    issue(14'h0085);
    check(got(), {ALU_STORE, 2'b10, 3'b000});
    issue(14'h0060);
    check(got(), {ALU_NONE, 2'b00, 3'b000});
    issue(14'h1285);
    check(got(), {ALU_BCLR, 5'b10000});
    check({bit_idx, file_addr}, {3'h5, 7'h05});
    issue(14'h1685);
    check(got(), {ALU_BSET, 5'b10000});
    issue(14'h0064);
    check({watchdog_clear, standby_enter, upd_to_pd}, 3'h5);
    follow(1'b0);
    issue(14'h0063);
    check({watchdog_clear, standby_enter, upd_to_pd}, 3'h3);
    follow(1'b0);
  endtask

  task automatic branch_ops();
    issue(14'h22AB);
    check({pc_call, pc_jump, target_addr}, {2'b10, 11'h2AB});
    check(nop_next, 1'b1);
    follow(1'b1);
    issue(14'h2D55);
    check({pc_call, pc_jump, target_addr}, {2'b01, 11'h555});
    follow(1'b1);
    issue(14'h0008);
    check({pc_return, interrupt_return}, 2'h2);
    follow(1'b1);
    issue(14'h0009);
    check(interrupt_return, 1'b1);
    follow(1'b1);
    issue(14'h3455);
    check({alu_op, literal}, {ALU_LOAD, 8'h55});
    follow(1'b1);
  endtask

  task automatic skip_case(input logic [13:0] w, input logic [7:0] v,
                           input logic hit);
    mem_u.regs[7'h10] = v;
    issue(w);
    check({upd_carry, upd_digit_carry, upd_zero}, 3'h0);
    follow(hit);
  endtask

  task automatic port_and_timer();
    @(posedge mclk);
    file_is_port <= 1'b1;
    port_pins <= 8'h5A;
    mem_u.regs[7'h06] = 8'hFF;
    repeat (8) @(posedge mclk);
    issue(14'h0886);
    @(negedge mclk);
    check(operand, 8'h5A);
    @(posedge mclk) file_is_port <= 1'b0;
    prescaler_to_timer <= 1'b1;
    issue(14'h0081);
    check(prescaler_clear, 1'b1);
    issue(14'h0701);
    check(prescaler_clear, 1'b0);
    check(gap, 3);
    @(posedge mclk) prescaler_to_timer <= 1'b0;
    issue(14'h0081);
    check(prescaler_clear, 1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    sys_rst = 1'b1;
    file_is_port = 1'b0;
    prescaler_to_timer = 1'b0;
    port_pins = 8'h00;
    word_next = 14'h0000;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    byte_ops();
    lit_ops();
    fixed_ops();
    branch_ops();
    skip_case(14'h0B90, 8'h01, 1'b1);
    skip_case(14'h0B90, 8'h05, 1'b0);
    skip_case(14'h0F90, 8'hFF, 1'b1);
    skip_case(14'h0F90, 8'h00, 1'b0);
    skip_case(14'h1990, 8'hF7, 1'b1);
    skip_case(14'h1990, 8'h08, 1'b0);
    skip_case(14'h1D90, 8'h08, 1'b1);
    skip_case(14'h1D90, 8'hF7, 1'b0);
    port_and_timer();
    end_of_test();
  end
endmodule
